// [rtl/sbr_baud_gen.sv]
// prescaler and reloading down-counter of one channel's rate generator
// assumes select and divider come from registers in the clk_i domain
`timescale 1ns/1ps
module sbr_baud_gen
	import sbr_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic restart_i,
	// settings
	input wire logic [1:0] psc_sel_i,
	input wire logic [7:0] divider_i,
	// result
	output logic tick_o
);

	// ****************************************
	// prescaler
	// ****************************************
	logic [5:0] psc_reg;
	logic [7:0] cnt_reg;
	logic tick_reg;
	wire psc_wrap = (psc_reg >= sbr_psc_last(psc_sel_i)); // [RQ12]
	wire reload = psc_wrap && (cnt_reg == 8'h00);

	always_ff @(posedge clk_i) begin
		if (reset_i || (ce_i && restart_i)) begin
			psc_reg <= 6'h00;
		end else if (ce_i) begin
			psc_reg <= psc_wrap ? 6'h00 : psc_reg + 6'h01;
		end
	end

	// ****************************************
	// down-counter, loaded at reload and at restart
	// ****************************************
	// a new divider waits for the running count to expire, so no short period appears
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cnt_reg <= DIVIDER_RESET;
			tick_reg <= 1'b0;
		end else if (ce_i) begin
			if (restart_i) begin
				cnt_reg <= divider_i;
				tick_reg <= 1'b0;
			end else begin
				if (reload) begin
					cnt_reg <= divider_i; // [RQ18] [RQ14]
				end else if (psc_wrap) begin
					cnt_reg <= cnt_reg - 8'h01;
				end
				tick_reg <= reload; // [RQ18]
			end
		end
	end

	assign tick_o = tick_reg;

endmodule : sbr_baud_gen

// [rtl/sbr_pkg.sv]
// constants, field layouts and reset values of the serial pin port and bit-rate block
// assumes a 250 MHz peripheral clock and a 32-bit AHB-Lite register bus
//
// Overview of operation
// RQ1 - append multiproc value bit in async multiproc format
// RQ2 - ignore multiproc value otherwise or when idle
// RQ3 - clock pin mode: 00 hold, 01 drive, 10 read
// RQ4 - software clears sync and clock enables first
// RQ5 - output mode drives clock pin data level
// RQ6 - break mode 00 hold, 01 drive break data
// RQ7 - software clears transmit enable before break
// RQ8 - receive enable makes break data read receive pin
// RQ9 - break data undefined after power-on reset
// RQ10 - divider 8-bit, always RW, FF on reset/standby
// RQ11 - each channel owns its own rate generator
// RQ12 - prescaler: clock undivided, /4, /16, /64
// RQ13 - rate = clock/((N+1)*2^(2n-1)*64 or 8)
// RQ14 - every divider value 0..255 is valid
// RQ15 - software picks settings with error under 1%
// RQ16 - no continuous sync transfer at n=0, N=0
// RQ17 - external async clock is sixteen times rate
// RQ18 - down-counter reloads divider, tick per reload
package sbr_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PORT_CTRL = 8'h04;
	localparam logic [7:0] OFS_PORT_DATA = 8'h08;
	localparam logic [7:0] OFS_DIVIDER = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	// ****************************************
	// control register fields
	// ****************************************
	localparam int CTL_MPV = 0;
	localparam int CTL_CKE_LO = 1;
	localparam int CTL_CKE_HI = 2;
	localparam int CTL_PSC_LO = 3;
	localparam int CTL_PSC_HI = 4;
	localparam int CTL_SYNC = 5;
	localparam int CTL_MPF = 6;
	localparam int CTL_TE = 7;
	localparam int CTL_RE = 8;
	localparam int CTL_W = 9;
	localparam logic [8:0] CTL_RESET = 9'h000;

	// ****************************************
	// port control and data fields
	// ****************************************
	localparam int PC_CLK_LO = 2;
	localparam int PC_CLK_HI = 3;
	localparam int PC_BRK_LO = 0;
	localparam int PC_BRK_HI = 1;
	localparam logic [15:0] PORT_CTRL_RESET = 16'hA888;
	localparam int PD_CLK = 1;
	localparam int PD_BRK = 0;
	localparam logic [7:0] PORT_DATA_RESET = 8'h00;
	localparam logic [1:0] MODE_HOLD = 2'b00;
	localparam logic [1:0] MODE_DRIVE = 2'b01;
	localparam logic [1:0] MODE_READ = 2'b10;

	// ****************************************
	// rate generation
	// ****************************************
	localparam logic [7:0] DIVIDER_RESET = 8'hFF;
	localparam logic [4:0] ASYNC_STAGE_LAST = 5'h1F;
	localparam logic [4:0] SYNC_STAGE_LAST = 5'h03;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ACCESS = 2'b10
	} sbr_bus_state_t;

	// last count of the prescaler for a select code
	function automatic logic [5:0] sbr_psc_last(input logic [1:0] sel);
		unique case (sel)
			2'b00: sbr_psc_last = 6'h00;
			2'b01: sbr_psc_last = 6'h03;
			2'b10: sbr_psc_last = 6'h0F;
			2'b11: sbr_psc_last = 6'h3F;
		endcase
	endfunction : sbr_psc_last

endpackage : sbr_pkg

// [rtl/sbr_top.sv]
// serial pin port control and bit-rate generation of one serial channel
// assumes an AHB-Lite master, shifters outside that use the tick and pin signals
`timescale 1ns/1ps
module sbr_top
	import sbr_pkg::*;
(
	// clock, reset, enable, standby
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic standby_i,
	input wire logic module_standby_i,
	// ahb-lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// shifter side
	input wire logic tx_serial_i,
	input wire logic tx_active_i,
	input wire logic serial_sck_i,
	input wire logic serial_sck_oe_i,
	output logic tx_multiproc_bit_o,
	output logic sync_mode_o,
	output logic mp_format_o,
	output logic [1:0] clock_enable_o,
	output logic transmit_enable_o,
	output logic receive_enable_o,
	output logic bit_tick_o,
	output logic sample_tick_o,
	// pins
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe_o,
	input wire logic rxd_i,
	output logic txd_o,
	output logic txd_oe_o
);

	// ****************************************
	// registers and bus state
	// ****************************************
	sbr_bus_state_t state_reg;
	sbr_bus_state_t state_next;
	logic [7:0] addr_reg;
	logic write_reg;
	logic [31:0] hrdata_reg;
	logic hreadyout_reg;
	logic hresp_reg;
	logic [8:0] ctrl_reg;
	logic [15:0] port_ctrl_reg;
	logic [7:1] port_data_reg;
	logic break_data_reg;
	logic [7:0] divider_reg;
	logic [4:0] stage_reg;
	logic half_reg;
	logic bit_tick_reg;
	logic sample_tick_reg;
	logic brg_tick;
	logic tx_mpb_reg;
	logic sck_reg;
	logic sck_oe_reg;
	logic txd_reg;
	logic txd_oe_reg;

	// ****************************************
	// bus decode
	// ****************************************
	wire standby = standby_i || module_standby_i;
	wire take = hsel_i && htrans_i[1] && hready_i;
	wire wr_now = (state_reg == ST_ACCESS) && write_reg;
	wire wr_ctrl = wr_now && (addr_reg == OFS_CTRL);
	wire wr_pctl = wr_now && (addr_reg == OFS_PORT_CTRL);
	wire wr_pdat = wr_now && (addr_reg == OFS_PORT_DATA);
	wire wr_div = wr_now && (addr_reg == OFS_DIVIDER);

	// ****************************************
	// field views
	// ****************************************
	wire [1:0] clk_mode = port_ctrl_reg[PC_CLK_HI:PC_CLK_LO];
	wire [1:0] brk_mode = port_ctrl_reg[PC_BRK_HI:PC_BRK_LO];
	wire [1:0] psc_sel = {ctrl_reg[CTL_PSC_HI], ctrl_reg[CTL_PSC_LO]};
	wire sync_mode = ctrl_reg[CTL_SYNC];
	wire te = ctrl_reg[CTL_TE];
	wire re = ctrl_reg[CTL_RE];
	wire [4:0] stage_last = sync_mode ? SYNC_STAGE_LAST : ASYNC_STAGE_LAST;
	wire stage_wrap = brg_tick && (stage_reg == stage_last);

	// read view of the port data: pins show through where the modes say so
	wire clk_data_rd = (clk_mode == MODE_READ) ? sck_i : port_data_reg[PD_CLK]; // [RQ3]
	wire brk_data_rd = re ? rxd_i : break_data_reg; // [RQ8]
	wire [31:0] rd_port_data = {24'h000000, port_data_reg[7:2], clk_data_rd, brk_data_rd};
	wire [31:0] rd_status = {24'h000000, stage_reg, sck_i, rxd_i, tx_active_i};
	wire [31:0] rd_mux =
		(addr_reg == OFS_CTRL) ? {23'h0, ctrl_reg} :
		(addr_reg == OFS_PORT_CTRL) ? {16'h0000, port_ctrl_reg} :
		(addr_reg == OFS_PORT_DATA) ? rd_port_data :
		(addr_reg == OFS_DIVIDER) ? {24'h000000, divider_reg} :
		(addr_reg == OFS_STATUS) ? rd_status : 32'h00000000;

	// ****************************************
	// pin selection
	// ****************************************
	wire sck_port = (clk_mode == MODE_DRIVE);
	wire sck_next = sck_port ? port_data_reg[PD_CLK] : serial_sck_i; // [RQ5]
	wire sck_oe_next = sck_port || serial_sck_oe_i; // [RQ3]
	wire brk_on = (brk_mode == MODE_DRIVE);
	// break drive wins over the shifter; software is expected to drop transmit first
	wire txd_next = brk_on ? break_data_reg : (te ? tx_serial_i : 1'b1); // [RQ6] [RQ7]
	wire txd_oe_next = brk_on || te; // [RQ6]
	wire mpb_next = !sync_mode && ctrl_reg[CTL_MPF] && tx_active_i
		&& ctrl_reg[CTL_MPV]; // [RQ1] [RQ2]

	// ****************************************
	// bus state machine
	// ****************************************
	// one wait state per transfer so a write lands before any following read
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (take) begin
					state_next = ST_ACCESS;
				end
			end
			ST_ACCESS: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_reg <= ST_IDLE;
			addr_reg <= 8'h00;
			write_reg <= 1'b0;
			hreadyout_reg <= 1'b1;
			hrdata_reg <= 32'h00000000;
			hresp_reg <= 1'b0;
		end else if (ce_i) begin
			state_reg <= state_next;
			if (state_reg == ST_IDLE && take) begin
				addr_reg <= haddr_i[7:0];
				write_reg <= hwrite_i;
				hreadyout_reg <= 1'b0;
			end else if (state_reg == ST_ACCESS) begin
				hrdata_reg <= write_reg ? 32'h00000000 : rd_mux;
				hreadyout_reg <= 1'b1;
			end
		end
	end

	// ****************************************
	// control and port registers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ctrl_reg <= CTL_RESET;
			port_ctrl_reg <= PORT_CTRL_RESET;
			port_data_reg <= PORT_DATA_RESET[7:1];
		end else if (ce_i) begin
			if (wr_ctrl) begin
				ctrl_reg <= hwdata_i[CTL_W-1:0];
			end
			if (wr_pctl) begin
				port_ctrl_reg <= hwdata_i[15:0];
			end
			if (wr_pdat) begin
				port_data_reg <= hwdata_i[7:1];
			end
			if (clk_mode == MODE_READ) begin
				port_data_reg[PD_CLK] <= sck_i; // [RQ3]
			end
		end
	end

	// no reset: the level here is not defined until software writes it
	always_ff @(posedge clk_i) begin
		if (ce_i && wr_pdat) begin
			break_data_reg <= hwdata_i[PD_BRK]; // [RQ9]
		end
	end

	// ****************************************
	// divider register
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (reset_i || (ce_i && standby)) begin
			divider_reg <= DIVIDER_RESET; // [RQ10]
		end else if (ce_i && wr_div) begin
			divider_reg <= hwdata_i[7:0]; // [RQ10]
		end
	end

	// ****************************************
	// rate generator of this channel
	// ****************************************
	sbr_baud_gen u_baud_gen ( // [RQ11]
		.clk_i(clk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.restart_i(standby),
		.psc_sel_i(psc_sel),
		.divider_i(divider_reg),
		.tick_o(brg_tick)
	);

	// final stage: 32 ticks per bit async, 4 per bit sync, with the prescale this
	// gives clock/((N+1)*2^(2n-1)*64) or *8
	always_ff @(posedge clk_i) begin
		if (reset_i || (ce_i && standby)) begin
			stage_reg <= 5'h00;
			half_reg <= 1'b0;
			bit_tick_reg <= 1'b0;
			sample_tick_reg <= 1'b0;
		end else if (ce_i) begin
			if (brg_tick) begin
				stage_reg <= stage_wrap ? 5'h00 : stage_reg + 5'h01; // [RQ13]
				half_reg <= !half_reg;
			end
			bit_tick_reg <= stage_wrap; // [RQ13]
			sample_tick_reg <= sync_mode ? stage_wrap : (brg_tick && half_reg);
		end
	end

	// ****************************************
	// pin and shifter outputs
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sck_reg <= 1'b0;
			sck_oe_reg <= 1'b0;
			txd_reg <= 1'b1;
			txd_oe_reg <= 1'b0;
			tx_mpb_reg <= 1'b0;
		end else if (ce_i) begin
			sck_reg <= sck_next;
			sck_oe_reg <= sck_oe_next;
			txd_reg <= txd_next;
			txd_oe_reg <= txd_oe_next;
			tx_mpb_reg <= mpb_next; // [RQ1] [RQ2]
		end
	end

	assign hrdata_o = hrdata_reg;
	assign hreadyout_o = hreadyout_reg;
	assign hresp_o = hresp_reg;
	assign tx_multiproc_bit_o = tx_mpb_reg;
	assign sync_mode_o = ctrl_reg[CTL_SYNC];
	assign mp_format_o = ctrl_reg[CTL_MPF];
	assign clock_enable_o = {ctrl_reg[CTL_CKE_HI], ctrl_reg[CTL_CKE_LO]};
	assign transmit_enable_o = ctrl_reg[CTL_TE];
	assign receive_enable_o = ctrl_reg[CTL_RE];
	assign bit_tick_o = bit_tick_reg;
	assign sample_tick_o = sample_tick_reg;
	assign sck_o = sck_reg;
	assign sck_oe_o = sck_oe_reg;
	assign txd_o = txd_reg;
	assign txd_oe_o = txd_oe_reg;

endmodule : sbr_top

// [verification/sbr_peer.sv]
// remote serial peer on the receive and clock pins
// assumes the bench chooses the levels it presents
`timescale 1ns/1ps
module sbr_peer (
	// levels chosen by the bench
	input wire logic clk_i,
	input wire logic rx_lvl_i,
	input wire logic ck_lvl_i,
	// pins
	output logic rxd_o,
	output logic sck_o
);
	// ****
	// pin drive
	// ****
	// levels move on a rising clock edge, one cycle after the bench sets them
	always_ff @(posedge clk_i) begin
		rxd_o <= rx_lvl_i;
		// only steady levels here; an external async clock would run at 16x the bit rate
		sck_o <= ck_lvl_i;
	end
endmodule : sbr_peer

// [verification/sbr_top_props.sv]
// assertions on the ports of the serial pin and bit-rate block
// assumes one clock domain, synchronous reset and ce_i held high
`timescale 1ns/1ps
module sbr_top_props (
	// clock and bus
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic hsel_i,
	input wire logic [1:0] htrans_i,
	input wire logic hready_i,
	input wire logic hreadyout_o,
	// shifter side and pins
	input wire logic tx_active_i,
	input wire logic tx_multiproc_bit_o,
	input wire logic sync_mode_o,
	input wire logic mp_format_o,
	input wire logic [1:0] clock_enable_o,
	input wire logic transmit_enable_o,
	input wire logic receive_enable_o,
	input wire logic bit_tick_o,
	input wire logic sample_tick_o,
	input wire logic sck_oe_o,
	input wire logic txd_o,
	input wire logic txd_oe_o
);
	// ****
	// properties
	// ****
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	sequence s_take;
		hsel_i && htrans_i[1] && hready_i && hreadyout_o;
	endsequence
	sequence s_answer;
		!hreadyout_o ##1 hreadyout_o;
	endsequence
	a_bus_answer: assert property (s_take |=> s_answer)
		else $error("bus answer out of time");
	a_wait_cause: assert property ($fell(hreadyout_o) |-> $past(hsel_i && htrans_i[1]))
		else $error("wait state without a transfer");
	a_reset_state: assert property ($fell(reset_i) |-> hreadyout_o && txd_o && !txd_oe_o
		&& !sck_oe_o && !bit_tick_o)
		else $error("pins not idle after reset");
	a_txd_idle: assert property (!txd_oe_o |-> txd_o)
		else $error("undriven transmit pin not high");
	// the extra bit only exists on an async multiprocessor frame being sent
	a_mp_gating: assert property (tx_multiproc_bit_o |->
		$past(!sync_mode_o && mp_format_o && tx_active_i))
		else $error("multiprocessor bit outside its format");
	a_tick_spacing: assert property (bit_tick_o |=> !bit_tick_o [*3])
		else $error("bit ticks closer than four cycles");
	a_sample_gap: assert property (sample_tick_o |=> !sample_tick_o)
		else $error("sample ticks back to back");
	a_sync_ticks: assert property (sync_mode_o && $stable(sync_mode_o) && bit_tick_o
		|-> sample_tick_o)
		else $error("sync bit tick without sample tick");
	a_ctrl_write: assert property ($changed({sync_mode_o, mp_format_o, clock_enable_o,
		transmit_enable_o, receive_enable_o}) |-> $past(hreadyout_o) == 1'b0)
		else $error("control bits moved without a write");
endmodule : sbr_top_props
bind sbr_top sbr_top_props u_props (.clk_i, .reset_i, .hsel_i, .htrans_i, .hready_i,
	.hreadyout_o, .tx_active_i, .tx_multiproc_bit_o, .sync_mode_o, .mp_format_o,
	.clock_enable_o, .transmit_enable_o, .receive_enable_o, .bit_tick_o, .sample_tick_o,
	.sck_oe_o, .txd_o, .txd_oe_o);

// [verification/testbench.sv]
// self-checking bench of the serial pin and bit-rate block
// assumes the peer model and a 250 MHz clock; bus driven as AHB-Lite master
`timescale 1ns/1ps
module testbench;
	import sbr_pkg::*;
	logic clk_i = 0, reset_i = 1, ce_i = 1, standby_i = 0, module_standby_i = 0;
	logic hsel_i = 0, hwrite_i = 0, tx_serial_i = 0, tx_active_i = 0;
	logic serial_sck_i = 0, serial_sck_oe_i = 0, rx_lvl = 1, ck_lvl = 0;
	logic [1:0] htrans_i = 2'h0;
	logic [2:0] hsize_i = 3'h2;
	logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, q;
	logic hreadyout_o, hresp_o, tx_multiproc_bit_o, sync_mode_o, mp_format_o, transmit_enable_o;
	logic receive_enable_o, bit_tick_o, sample_tick_o, sck_i, sck_o, sck_oe_o, rxd_i;
	logic txd_o, txd_oe_o;
	logic [1:0] clock_enable_o;
	logic [5:0] ctl_out;
	integer seed = 32'h8C63, errors = 0, tests_run = 0, cyc = 0, n, nv, k, sy, p, s;
	sbr_top DUT (.clk_i, .reset_i, .ce_i, .standby_i, .module_standby_i, .hsel_i, .haddr_i,
		.htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
		.hreadyout_o, .hresp_o, .tx_serial_i, .tx_active_i, .serial_sck_i, .serial_sck_oe_i,
		.tx_multiproc_bit_o, .sync_mode_o, .mp_format_o, .clock_enable_o, .transmit_enable_o,
		.receive_enable_o, .bit_tick_o, .sample_tick_o, .sck_i, .sck_o, .sck_oe_o, .rxd_i,
		.txd_o, .txd_oe_o);
	sbr_peer peer (.clk_i, .rx_lvl_i(rx_lvl), .ck_lvl_i(ck_lvl), .rxd_o(rxd_i), .sck_o(sck_i));
	// ****
	// helpers
	// ****
	initial forever #2 clk_i = ~clk_i;
	// all rate cases together take some 40k cycles at worst; ceiling leaves margin
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			errors++;
			stop_test();
		end
	end
	function automatic integer exp_per(input integer n, input integer nv, input integer sy);
		exp_per = (4 ** n) * (nv + 1) * (sy ? 4 : 32);
	endfunction : exp_per
	task stop_test;
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_i);
		hsel_i <= 1'b1;
		haddr_i <= {24'h0, a};
		htrans_i <= 2'h2;
		hwrite_i <= w;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= d;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		q = hrdata_o;
	endtask : xfer
	task per(output integer p, output integer s);
		p = 0;
		s = 0;
		repeat (2) do @(posedge clk_i); while (bit_tick_o !== 1'b1);
		do begin
			@(posedge clk_i);
			p++;
			if (sample_tick_o === 1'b1) begin
				s++;
			end
		end while (bit_tick_o !== 1'b1);
	endtask : per
	// ****
	// scenarios
	// ****
	initial begin
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		xfer(OFS_DIVIDER, 0, 0);
		chk("divider", 32'hFF, q);
		xfer(OFS_PORT_CTRL, 0, 0);
		chk("port_ctrl", 32'hA888, q);
		xfer(8'h14, 0, 0);
		chk("unmapped", 32'h0, q);
		chk("hresp", 1'b0, hresp_o);
		for (k = 0; k < 4; k++) begin
			nv = (k == 3) ? 255 : (k == 0) ? 0 : $random(seed) & 255;
			xfer(OFS_DIVIDER, 1, nv);
			xfer(OFS_DIVIDER, 0, 0);
			chk("divider_rw", nv, q);
		end
		tx_active_i <= 1'b1;
		for (k = 0; k < 3; k++) begin
			if (k == 2) tx_active_i <= 1'b0;
			xfer(OFS_CTRL, 1, (k == 1) ? 32'h61 : 32'h41);
			repeat (2) @(posedge clk_i);
			chk("mp_bit", k == 0, tx_multiproc_bit_o);
		end
		xfer(OFS_CTRL, 1, 32'h80);
		for (k = 0; k < 2; k++) begin
			tx_serial_i <= k[0];
			repeat (2) @(posedge clk_i);
			chk("tx_path", {1'b1, k[0]}, {txd_oe_o, txd_o});
		end
		// transmit enable cleared before the pin is taken over
		xfer(OFS_CTRL, 1, 32'h0);
		xfer(OFS_PORT_CTRL, 1, 32'hA889);
		for (k = 0; k < 2; k++) begin
			xfer(OFS_PORT_DATA, 1, k);
			repeat (2) @(posedge clk_i);
			chk("break", {1'b1, k[0]}, {txd_oe_o, txd_o});
		end
		// receive enable on, sync and clock enables off for port use
		xfer(OFS_CTRL, 1, 32'h100);
		for (k = 0; k < 2; k++) begin
			rx_lvl <= k[0];
			ck_lvl <= k[0];
			repeat (3) @(posedge clk_i);
			xfer(OFS_PORT_DATA, 0, 0);
			chk("pin_read", {k[0], k[0]}, q[1:0]);
			xfer(OFS_STATUS, 0, 0);
			chk("status", {k[0], k[0], 1'b0}, q[2:0]);
		end
		xfer(OFS_PORT_CTRL, 1, 32'hA885);
		for (k = 0; k < 2; k++) begin
			xfer(OFS_PORT_DATA, 1, k << 1);
			repeat (2) @(posedge clk_i);
			chk("clk_drive", {1'b1, k[0]}, {sck_oe_o, sck_o});
		end
		xfer(OFS_PORT_CTRL, 1, 32'hA881);
		repeat (2) @(posedge clk_i);
		chk("clk_hold", 1'b0, sck_oe_o);
		serial_sck_i <= 1'b1;
		serial_sck_oe_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk("clk_pass", 2'b11, {sck_oe_o, sck_o});
		serial_sck_i <= 1'b0;
		serial_sck_oe_i <= 1'b0;
		nv = $random(seed) & 32'h1FF;
		xfer(OFS_CTRL, 1, nv);
		xfer(OFS_CTRL, 0, 0);
		chk("ctrl_rw", nv, q);
		ctl_out = {receive_enable_o, transmit_enable_o, mp_format_o, sync_mode_o, clock_enable_o};
		chk("ctrl_out", {nv[8:5], nv[2:1]}, ctl_out);
		for (k = 0; k < 9; k++) begin
			n = (k == 8) ? 0 : k & 3;
			sy = (k < 4 || k == 8);
			nv = (k == 8) ? 255 : $random(seed) & 3;
			xfer(OFS_DIVIDER, 1, nv);
			xfer(OFS_CTRL, 1, (sy << 5) | (n << 3));
			per(p, s);
			chk("bit_period", exp_per(n, nv, sy), p);
			chk("samples", sy ? 1 : 16, s);
		end
		for (k = 0; k < 2; k++) begin
			xfer(OFS_DIVIDER, 1, 32'h5A);
			standby_i <= k[0];
			module_standby_i <= ~k[0];
			@(posedge clk_i);
			standby_i <= 1'b0;
			module_standby_i <= 1'b0;
			xfer(OFS_DIVIDER, 0, 0);
			chk("standby_div", 32'hFF, q);
		end
		stop_test();
	end
endmodule : testbench
